// file: shared/byte_swap_pkg.sv
`default_nettype none
package byte_swap_pkg;

    // opcodes of the byte swap instruction
    localparam logic [7:0] OP_INDIRECT    = 8'h52;
    localparam logic [7:0] OP_DIRECT_FE   = 8'h53;
    localparam logic [7:0] OP_DIRECT_00   = 8'h54;
    localparam logic [7:0] OP_DIRECT_01   = 8'h55;
    localparam logic [7:0] OP_DIRECT_LONG = 8'h56;

    // fixed high address bytes of the short direct encodings
    localparam logic [7:0] PAGE_00 = 8'h00;
    localparam logic [7:0] PAGE_01 = 8'h01;
    localparam logic [7:0] PAGE_FE = 8'hfe;

    // second byte fields of the indirect form
    localparam int OFF_FORM_BIT = 7;
    localparam int DISP_BIT     = 0;
    localparam int IDX_LSB      = 1;
    localparam int IDX_W        = 6;
    localparam int OFF_W        = 7;

    // status swap bit position in the program status word
    localparam int STATUS_SWAP_POS = 1;

    // instruction lengths in bytes
    localparam logic [1:0] LEN_SHORT = 2'h2;
    localparam logic [1:0] LEN_LONG  = 2'h3;

    // cycles from acceptance to capture of the operands
    localparam int IND_CYCLES   = 2;
    localparam int SHORT_CYCLES = 1;
    localparam int LONG_CYCLES  = 2;

    // reset values
    localparam logic [15:0] ADDR_RST = 16'h0000;
    localparam logic [7:0]  BYTE_RST = 8'h00;

    typedef struct packed {
        logic [7:0] op;
        logic [7:0] b1;
        logic [7:0] b2;
    } instr_t;

    typedef enum logic [1:0] {
        FORM_NONE,
        FORM_INDIRECT,
        FORM_SHORT,
        FORM_LONG
    } form_t;

    // a memory word with its optional ninth bit
    typedef struct packed {
        logic       ninth;
        logic [7:0] data;
    } mem_word_t;

endpackage : byte_swap_pkg
`default_nettype wire

// file: design/byte_swap_addr_gen.sv
`timescale 1ns/100ps
`default_nettype none
module byte_swap_addr_gen
    import byte_swap_pkg::*;
(
    // instruction and operands
    input  wire instr_t      ins,
    input  wire logic [15:0] ptr_word,
    input  wire logic [7:0]  disp,
    // decoded results
    output form_t            form,
    output logic [1:0]       len,
    output logic [15:0]      ptr_addr,
    output logic [15:0]      ind_addr,
    output logic [15:0]      dir_addr
);

    logic [IDX_W-1:0] idx;
    logic [15:0]      disp_ext;
    logic [15:0]      off_ext;

    assign idx = ins.b1[IDX_LSB +: IDX_W];
    // pointer n sits at bytes 2n (low half) and 2n+1
    assign ptr_addr = ins.b1[OFF_FORM_BIT] ? ADDR_RST
                    : {{(15-IDX_W){1'b0}}, idx, 1'b0};
    assign disp_ext = {{8{disp[7]}}, disp};
    assign off_ext  = {{(16-OFF_W){ins.b1[OFF_W-1]}},
                       ins.b1[OFF_W-1:0]};

    always_comb begin
        if (ins.b1[OFF_FORM_BIT]) begin
            ind_addr = ptr_word + off_ext;
        end else if (ins.b1[DISP_BIT]) begin
            ind_addr = ptr_word + disp_ext;
        end else begin
            ind_addr = ptr_word;
        end
    end

    always_comb begin
        form     = FORM_NONE;
        len      = LEN_SHORT;
        dir_addr = {ins.b2, ins.b1};
        case (ins.op)
            OP_INDIRECT: begin
                form = FORM_INDIRECT;
            end
            OP_DIRECT_00: begin
                form     = FORM_SHORT;
                dir_addr = {PAGE_00, ins.b1};
            end
            OP_DIRECT_01: begin
                form     = FORM_SHORT;
                dir_addr = {PAGE_01, ins.b1};
            end
            OP_DIRECT_FE: begin
                form     = FORM_SHORT;
                dir_addr = {PAGE_FE, ins.b1};
            end
            OP_DIRECT_LONG: begin
                form = FORM_LONG;
                len  = LEN_LONG;
            end
            default: begin
                form = FORM_NONE;
            end
        endcase
    end

endmodule : byte_swap_addr_gen
`default_nettype wire

// file: design/byte_swap_unit.sv
// Function
// - 52H with second byte bit7=0, bit0=0 swaps A with byte at pointer n.
// - pointer index 0 to 63 taken from six bits of the second byte.
// - pointer n lives at RAM bytes 2n (low half) and 2n+1.
// - second byte bit7=0, bit0=1 adds the displacement register to the pointer.
// - displacement register is signed 8 bits, -128 to 127.
// - second byte bit7=1 addresses pointer zero plus the low seven bits.
// - the seven-bit offset is signed, -64 to 63.
// - indirect forms are two bytes, two cycles, program counter plus two.
// - status swap bit swaps with the target ninth bit where one exists.
// - the status swap bit is bit 1 of the program status word.
// - direct: 54H page 00, 55H page 01, 53H page FE, 56H full address.
// - two-byte direct takes one cycle, three-byte two; pc plus length.
`timescale 1ns/100ps
`default_nettype none
module byte_swap_unit
    import byte_swap_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // instruction issue
    input  wire logic        start,
    input  wire instr_t      ins_in,
    output logic             ready,
    output logic             done,
    output logic [1:0]       pc_adv,
    // core registers
    input  wire logic [7:0]  acc_in,
    input  wire logic [7:0]  disp_in,
    input  wire logic [7:0]  psw_in,
    output logic             acc_we,
    output logic [7:0]       acc_wdata,
    output logic             psw_we,
    output logic [7:0]       psw_wdata,
    // pointer word read port, data valid in the same cycle
    output logic [15:0]      ptr_addr,
    input  wire logic [15:0] ptr_rdata,
    // target read and write port, read data valid in the same cycle
    output logic             mem_rd,
    output logic             mem_we,
    output logic [15:0]      mem_addr,
    input  wire mem_word_t   mem_rdata,
    input  wire logic        mem_has_ninth,
    output mem_word_t        mem_wdata
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PTR,
        ST_LONG,
        ST_SWAP,
        ST_WB
    } state_t;

    state_t      state_r;
    instr_t      ins_r;
    logic [1:0]  len_r;
    logic [15:0] ptr_addr_r;
    logic [15:0] mem_addr_r;
    mem_word_t   tgt_cap_r;
    logic [7:0]  acc_cap_r;
    logic [7:0]  psw_cap_r;
    logic        ninth_cap_r;

    form_t       form_in;
    logic [1:0]  len_in;
    logic [15:0] ptr_addr_in;
    logic [15:0] dir_addr_in;
    logic [15:0] ind_addr;

    // decode of the new instruction, used at acceptance
    byte_swap_addr_gen u_dec_new (
        .ins      (ins_in),
        .ptr_word (ptr_rdata),
        .disp     (disp_in),
        .form     (form_in),
        .len      (len_in),
        .ptr_addr (ptr_addr_in),
        .ind_addr (),
        .dir_addr (dir_addr_in)
    );

    // decode of the held instruction, used once the pointer is read
    byte_swap_addr_gen u_dec_held (
        .ins      (ins_r),
        .ptr_word (ptr_rdata),
        .disp     (disp_in),
        .form     (),
        .len      (),
        .ptr_addr (),
        .ind_addr (ind_addr),
        .dir_addr ()
    );

    // opcodes outside this unit are left for other decoders
    logic accept;
    assign ready  = (state_r == ST_IDLE);
    assign accept = ready && start && (form_in != FORM_NONE);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (accept) begin
                        case (form_in)
                            FORM_INDIRECT: state_r <= ST_PTR;
                            FORM_LONG:     state_r <= ST_LONG;
                            default:       state_r <= ST_SWAP;
                        endcase
                    end
                end
                ST_PTR:  state_r <= ST_SWAP;
                ST_LONG: state_r <= ST_SWAP;
                ST_SWAP: state_r <= ST_WB;
                ST_WB:   state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ins_r      <= '0;
            len_r      <= LEN_SHORT;
            ptr_addr_r <= ADDR_RST;
        end else if (accept) begin
            ins_r      <= ins_in;
            len_r      <= len_in;
            ptr_addr_r <= ptr_addr_in;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_addr_r <= ADDR_RST;
        end else if (accept && form_in != FORM_INDIRECT) begin
            mem_addr_r <= dir_addr_in;
        end else if (state_r == ST_PTR) begin
            mem_addr_r <= ind_addr;
        end
    end

    // every operand is sampled on one edge, so nothing is written half-way
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tgt_cap_r   <= '0;
            acc_cap_r   <= BYTE_RST;
            psw_cap_r   <= BYTE_RST;
            ninth_cap_r <= 1'b0;
        end else if (state_r == ST_SWAP) begin
            tgt_cap_r   <= mem_rdata;
            acc_cap_r   <= acc_in;
            psw_cap_r   <= psw_in;
            ninth_cap_r <= mem_has_ninth;
        end
    end

    assign ptr_addr = ptr_addr_r;
    assign mem_addr = mem_addr_r;
    assign mem_rd   = (state_r == ST_SWAP);
    assign done     = (state_r == ST_WB);
    assign mem_we   = done;
    assign acc_we   = done;
    assign psw_we   = done && ninth_cap_r;
    assign pc_adv   = len_r;
    assign acc_wdata = tgt_cap_r.data;

    // without a ninth bit the stored one is written back unchanged
    always_comb begin
        mem_wdata.data  = acc_cap_r;
        mem_wdata.ninth = ninth_cap_r ? psw_cap_r[STATUS_SWAP_POS]
                                      : tgt_cap_r.ninth;
        psw_wdata = psw_cap_r;
        psw_wdata[STATUS_SWAP_POS] = ninth_cap_r ? tgt_cap_r.ninth
                                   : psw_cap_r[STATUS_SWAP_POS];
    end

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    logic [15:0] disp_ext;
    logic [15:0] off_ext;
    assign disp_ext = {{8{disp_in[7]}}, disp_in};
    assign off_ext  = {{9{ins_r.b1[6]}}, ins_r.b1[6:0]};

    sequence s_accept_ind;
        accept && form_in == FORM_INDIRECT;
    endsequence

    sequence s_writeback(int n);
        !done [*2] ##1 (done && pc_adv == n);
    endsequence

    ptr_slot_a: assert property ((s_accept_ind and !ins_in.b1[7])
        |=> ptr_addr == {9'h000, $past(ins_in.b1[6:1]), 1'b0})
        else $error("pointer slot address wrong");
    ptr_range_a: assert property (state_r == ST_PTR
        |-> ptr_addr[15:7] == 9'h000)
        else $error("pointer index out of range");
    ptr_zero_a: assert property ((s_accept_ind and ins_in.b1[7])
        |=> ptr_addr == 16'h0000)
        else $error("offset form not using pointer zero");
    disp_add_a: assert property (state_r == ST_PTR && !ins_r.b1[7]
        && ins_r.b1[0] |=> mem_addr == $past(ptr_rdata)
        + $past(disp_ext))
        else $error("displacement address wrong");
    disp_sign_a: assert property (state_r == ST_PTR && !ins_r.b1[7]
        && ins_r.b1[0] && disp_in[7] |=> mem_addr
        == 16'($past(ptr_rdata) - (9'h100 - $past(disp_in))))
        else $error("displacement not signed");
    off_add_a: assert property (state_r == ST_PTR && ins_r.b1[7]
        |=> mem_addr == $past(ptr_rdata) + $past(off_ext))
        else $error("offset address wrong");
    off_sign_a: assert property (state_r == ST_PTR && ins_r.b1[7]
        && ins_r.b1[6] |=> mem_addr
        == 16'($past(ptr_rdata) - (8'h80 - {1'b0, $past(ins_r.b1[6:0])})))
        else $error("offset not signed");
    ind_time_a: assert property (s_accept_ind
        |=> s_writeback(2))
        else $error("indirect swap timing wrong");
    ninth_swap_a: assert property (state_r == ST_SWAP && mem_has_ninth
        |=> psw_we && psw_wdata[1] == $past(mem_rdata.ninth)
        && mem_wdata.ninth == $past(psw_in[1]))
        else $error("ninth bit not swapped");
    psw_keep_a: assert property (done |-> psw_wdata[7:2]
        == $past(psw_in[7:2]) && psw_wdata[0] == $past(psw_in[0]))
        else $error("other status bits disturbed");
    page01_a: assert property (accept && ins_in.op == OP_DIRECT_01
        |=> mem_addr == {8'h01, $past(ins_in.b1)})
        else $error("page 01 address wrong");
    pagefe_a: assert property (accept && ins_in.op == OP_DIRECT_FE
        |=> mem_addr == {8'hfe, $past(ins_in.b1)})
        else $error("page fe address wrong");
    short_time_a: assert property (accept && form_in == FORM_SHORT
        |=> !done ##1 (done && pc_adv == 2'h2))
        else $error("short direct timing wrong");
    long_time_a: assert property (accept && form_in == FORM_LONG
        |=> !done [*2] ##1 (done && pc_adv == 2'h3))
        else $error("long direct timing wrong");
    atomic_a: assert property (state_r == ST_SWAP
        |=> mem_wdata.data == $past(acc_in)
        && acc_wdata == $past(mem_rdata.data))
        else $error("swap not atomic");

endmodule : byte_swap_unit
`default_nettype wire

// file: bench/byte_swap_unit_test.sv
`timescale 1ns/100ps
`default_nettype none
module byte_swap_unit_test
    import byte_swap_pkg::*;
;
    logic        clk;
    logic        rst_b;
    logic        start;
    instr_t      ins_in;
    logic        ready;
    logic        done;
    logic [1:0]  pc_adv;
    logic [7:0]  acc_in;
    logic [7:0]  disp_in;
    logic [7:0]  psw_in;
    logic        acc_we;
    logic [7:0]  acc_wdata;
    logic        psw_we;
    logic [7:0]  psw_wdata;
    logic [15:0] ptr_addr;
    logic [15:0] ptr_rdata;
    logic        mem_rd;
    logic        mem_we;
    logic [15:0] mem_addr;
    mem_word_t   mem_rdata;
    logic        mem_has_ninth;
    mem_word_t   mem_wdata;
    mem_word_t   tgt;
    logic [7:0]  pram [0:127];
    int          err_count;
    int          comparisons;
    int          seed;

    byte_swap_unit dut (.clk(clk), .rst_b(rst_b), .start(start),
        .ins_in(ins_in), .ready(ready), .done(done), .pc_adv(pc_adv),
        .acc_in(acc_in), .disp_in(disp_in), .psw_in(psw_in),
        .acc_we(acc_we), .acc_wdata(acc_wdata), .psw_we(psw_we),
        .psw_wdata(psw_wdata), .ptr_addr(ptr_addr),
        .ptr_rdata(ptr_rdata), .mem_rd(mem_rd), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .mem_has_ninth(mem_has_ninth), .mem_wdata(mem_wdata));

    // pointer words live in low ram, high byte above low byte
    assign ptr_rdata = {pram[ptr_addr[6:0] + 7'h01],
                        pram[ptr_addr[6:0]]};
    // target port shows garbage when not read, so a read in the wrong
    // cycle cannot pass by luck
    assign mem_rdata = mem_rd ? tgt : ~tgt;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    function automatic logic [15:0] exp_addr(input instr_t i);
        logic [15:0] pw;
        pw = {pram[{i.b1[6:1], 1'b1}], pram[{i.b1[6:1], 1'b0}]};
        case (i.op)
            OP_DIRECT_00:   return {PAGE_00, i.b1};
            OP_DIRECT_01:   return {PAGE_01, i.b1};
            OP_DIRECT_FE:   return {PAGE_FE, i.b1};
            OP_DIRECT_LONG: return {i.b2, i.b1};
            default: begin
                if (i.b1[7])
                    return {pram[1], pram[0]}
                           + {{9{i.b1[6]}}, i.b1[6:0]};
                if (i.b1[0])
                    return pw + {{8{disp_in[7]}}, disp_in};
                return pw;
            end
        endcase
    endfunction : exp_addr

    // one instruction, issued as soon as the unit is idle
    task automatic issue(input instr_t i, input logic [7:0] d);
        int          n;
        int          ncyc;
        logic        nin;
        logic [1:0]  elen;
        logic [15:0] ea;
        logic [15:0] eptr;
        mem_word_t   ewd;
        logic [7:0]  epsw;
        n = 0;
        while (ready !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        // a unit that never returns to idle is a hang, counted as a miss
        if (n >= 10) begin
            err_count++;
            print_verdict();
        end
        acc_in = 8'($random(seed));
        psw_in = 8'($random(seed));
        disp_in = d;
        tgt = 9'($random(seed));
        nin = 1'($random(seed));
        mem_has_ninth = nin;
        ea = exp_addr(i);
        ins_in = i;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        ins_in = 24'($random(seed));
        n = 1;
        while (done !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        ncyc = (i.op == OP_INDIRECT || i.op == OP_DIRECT_LONG) ? 3 : 2;
        elen = (i.op == OP_DIRECT_LONG) ? LEN_LONG : LEN_SHORT;
        eptr = i.b1[7] ? ADDR_RST : 16'({i.b1[6:1], 1'b0});
        ewd  = {nin ? psw_in[STATUS_SWAP_POS] : tgt.ninth, acc_in};
        epsw = {psw_in[7:2], tgt.ninth, psw_in[0]};
        check("cycles", 16'(n), 16'(ncyc));
        if (n >= 10)
            print_verdict();
        check("pc_adv", 16'(pc_adv), 16'(elen));
        if (i.op == OP_INDIRECT)
            check("ptr_addr", ptr_addr, eptr);
        check("mem_addr", mem_addr, ea);
        check("writes", {acc_we, mem_we, psw_we}, {2'b11, nin});
        check("acc_wdata", acc_wdata, tgt.data);
        check("mem_wdata", mem_wdata, ewd);
        if (nin)
            check("psw_wdata", psw_wdata, epsw);
        if (ea < 16'h0080)
            pram[ea[6:0]] = acc_in;
    endtask : issue

    instr_t      corner [11];
    logic [7:0]  cdisp  [11];
    logic [7:0]  bad    [3];
    logic [7:0]  ops    [5];

    initial begin
        err_count = 0;
        comparisons = 0;
        seed = 32'hc160;
        rst_b = 1'b0;
        start = 1'b0;
        ins_in = '0;
        acc_in = 8'h00;
        disp_in = 8'h00;
        psw_in = 8'h00;
        mem_has_ninth = 1'b0;
        tgt = '0;
        for (int a = 0; a < 128; a++)
            pram[a] = 8'($random(seed));
        corner = '{'{OP_INDIRECT, 8'h7e, 8'h00}, '{OP_INDIRECT, 8'h00, 8'h00},
                   '{OP_INDIRECT, 8'h03, 8'h00}, '{OP_INDIRECT, 8'h7f, 8'h00},
                   '{OP_INDIRECT, 8'hc0, 8'h00}, '{OP_INDIRECT, 8'hbf, 8'h00},
                   '{OP_INDIRECT, 8'h81, 8'h00}, '{OP_DIRECT_FE, 8'hff, 8'h00},
                   '{OP_DIRECT_00, 8'h11, 8'h00}, '{OP_DIRECT_01, 8'h00, 8'h00},
                   '{OP_DIRECT_LONG, 8'hff, 8'hff}};
        cdisp = '{8'h00, 8'h00, 8'h80, 8'h7f, 8'h00, 8'h00, 8'h80,
                  8'h00, 8'h00, 8'h00, 8'h00};
        bad = '{8'h51, 8'h57, 8'hd2};
        ops = '{OP_INDIRECT, OP_DIRECT_FE, OP_DIRECT_00, OP_DIRECT_01,
                OP_DIRECT_LONG};
        repeat (5) @(negedge clk);
        check("reset outs", {ready, done, acc_we, mem_we, psw_we, pc_adv},
              {5'b10000, LEN_SHORT});
        rst_b = 1'b1;
        @(negedge clk);
        // back to back, boundary indices, offsets and displacements
        for (int c = 0; c < 11; c++)
            issue(corner[c], cdisp[c]);
        // opcodes outside the swap family must leave the unit idle
        foreach (bad[b]) begin
            @(negedge clk);
            ins_in = {bad[b], 8'h02, 8'h00};
            start = 1'b1;
            @(negedge clk);
            start = 1'b0;
            repeat (4) begin
                check("refused", {ready, done, mem_we}, 3'b100);
                @(negedge clk);
            end
        end
        for (int r = 0; r < 60; r++)
            issue({ops[$unsigned($random(seed)) % 5], 8'($random(seed)),
                   8'($random(seed))}, 8'($random(seed)));
        print_verdict();
    end
endmodule : byte_swap_unit_test
`default_nettype wire
